// ===== common/psl_led_if.sv
// link/activity indicator signals between the pin top and its blink engine
// assumes both ends run on the core clock
`timescale 1ns/100ps
interface psl_led_if;
  logic link_up;
  logic activity;
  logic led_enable;
  logic led_n;

  modport ctrl (
    output link_up,
    output activity,
    output led_enable,
    input led_n
  );

  modport engine (
    input link_up,
    input activity,
    input led_enable,
    output led_n
  );
endinterface

// ===== common/psl_pkg.sv
// constants for the dual-use strap and indicator pin logic
// assumes a 250 MHz core clock and a 16-bit local register port
package psl_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STRAP = 4'h1;
  localparam logic [3:0] ADDR_INT_STAT = 4'h2;
  localparam logic [3:0] ADDR_INT_MASK = 4'h3;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int CTRL_LED_EN_BIT = 0;
  localparam int CTRL_SPEED_BIT = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam logic [15:0] CTRL_WMASK = 16'h2001;
  localparam int STRAP_ADDR0_BIT = 0;
  localparam int STRAP_TEST_BIT = 1;
  localparam int STRAP_SPEED_BIT = 2;
  localparam int INT_W = 3;
  localparam int EV_LINK_UP = 0;
  localparam int EV_LINK_DOWN = 1;
  localparam int EV_SPEED = 2;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 4;
  localparam longint BLINK_TIME_NS = 50000000;
  localparam int BLINK_CYCLES = int'(BLINK_TIME_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  typedef enum logic {PS_SAMPLE, PS_DRIVE} psl_pin_state_t;

endpackage

// ===== rtl/psl_link_act.sv
// link/activity indicator engine with its blink divider
// assumes link and activity levels synchronous to the core clock
`timescale 1ns/100ps
module psl_link_act #(
  parameter int BLINK_CYCLES = psl_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // indicator request and state
  psl_led_if.engine led
);

  localparam int CW = $clog2(BLINK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(BLINK_CYCLES - 1);

  logic [CW-1:0] div;
  logic tick;
  logic blink;

  // ----------------------------------------------------------------
  // blink divider
  // ----------------------------------------------------------------
  // the divider restarts whenever traffic stops so the first blink is a full period
  assign tick = (div == LAST);

  always_ff @(posedge clk) begin
    if (rst || tick || !led.activity) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !led.activity) begin
      blink <= 1'b0;
    end else if (tick) begin
      blink <= ~blink;
    end
  end

  // ----------------------------------------------------------------
  // indicator level
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      led.led_n <= 1'b1;
    end else if (!led.link_up || !led.led_enable) begin
      led.led_n <= 1'b1;
    end else begin
      // gated by activity so the indicator is back on one cycle after traffic stops
      led.led_n <= blink && led.activity;
    end
  end

endmodule

// ===== rtl/psl_strap_pins.sv
// dual-use strap and indicator pins of a 10/100 transceiver core
// Notes on behaviour
// - after reset the interrupt pin drives the management interrupt, low when asserted
// - the interrupt pin level during reset becomes management address bit 0
// - without link the link/activity indicator is held high, indicator off
// - with link the indicator is low; it toggles while traffic is seen
// - the link/activity indicator is active low
// - link/activity pin pulled low during reset selects factory test mode
// - speed pin level during reset loads speed select, control bit 13
// assumes all inputs synchronous to CORE_CLK and straps stable while RST is high
`timescale 1ns/100ps
module psl_strap_pins #(
  parameter int BLINK_CYCLES = psl_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register port
  input wire logic [psl_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [psl_pkg::REG_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [psl_pkg::REG_DW-1:0] REG_RDATA,
  // link status from the core
  input wire logic LINK_UP,
  input wire logic ACTIVITY,
  input wire logic SPEED_100,
  // interrupt pin, also address strap
  input wire logic MGMT_INT_N_I,
  output logic MGMT_INT_N_O,
  output logic MGMT_INT_N_OE,
  // link/activity indicator pin, also test strap
  input wire logic LINK_ACT_INDICATOR_N_I,
  output logic LINK_ACT_INDICATOR_N_O,
  output logic LINK_ACT_INDICATOR_N_OE,
  // speed indicator pin, also speed strap
  input wire logic SPEED_INDICATOR_N_I,
  output logic SPEED_INDICATOR_N_O,
  output logic SPEED_INDICATOR_N_OE,
  // latched configuration
  output logic PHY_ADDR_STRAP,
  output logic TEST_MODE,
  output logic SPEED_SEL
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  psl_pkg::psl_pin_state_t pin_state;
  psl_pkg::psl_pin_state_t next_pin_state;
  logic [psl_pkg::REG_DW-1:0] ctrl;
  logic [psl_pkg::INT_W-1:0] int_stat;
  logic [psl_pkg::INT_W-1:0] int_mask;
  logic [psl_pkg::INT_W-1:0] int_event;
  logic [psl_pkg::INT_W-1:0] int_clear;
  logic phy_addr_strap;
  logic test_strap;
  logic speed_strap_pin;
  logic link_prev;
  logic speed_prev;
  logic drive;
  logic int_n;
  logic speed_led_n;
  logic irq_pending;
  logic [psl_pkg::REG_DW-1:0] rd_value;

  psl_led_if led_bus();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(
    input logic [psl_pkg::REG_AW-1:0] addr,
    input logic [psl_pkg::REG_AW-1:0] target
  );
    addr_hit = (addr == target);
  endfunction

  function automatic logic [psl_pkg::REG_DW-1:0] pad_int(
    input logic [psl_pkg::INT_W-1:0] bits
  );
    pad_int = '0;
    pad_int[psl_pkg::INT_W-1:0] = bits;
  endfunction

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  // pins stay released for the whole reset so the strap resistors set the level
  always_comb begin
    next_pin_state = pin_state;
    unique case (pin_state)
      psl_pkg::PS_SAMPLE: begin
        next_pin_state = psl_pkg::PS_DRIVE;
      end
      psl_pkg::PS_DRIVE: begin
        next_pin_state = psl_pkg::PS_DRIVE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pin_state <= psl_pkg::PS_SAMPLE;
    end else begin
      pin_state <= next_pin_state;
    end
  end

  assign drive = (pin_state == psl_pkg::PS_DRIVE);

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // the value held is the level seen on the last cycle of reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      phy_addr_strap <= MGMT_INT_N_I;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      test_strap <= LINK_ACT_INDICATOR_N_I;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      speed_strap_pin <= SPEED_INDICATOR_N_I;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // speed select takes the strap in reset and can be rewritten afterwards
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl <= psl_pkg::CTRL_RESET;
      ctrl[psl_pkg::CTRL_SPEED_BIT] <= SPEED_INDICATOR_N_I;
    end else if (REG_WR && addr_hit(REG_ADDR, psl_pkg::ADDR_CTRL)) begin
      ctrl <= REG_WDATA & psl_pkg::CTRL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      link_prev <= 1'b0;
    end else begin
      link_prev <= LINK_UP;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      speed_prev <= 1'b0;
    end else begin
      speed_prev <= SPEED_100;
    end
  end

  // speed changes count only while the link is up, to avoid noise during training
  always_comb begin
    int_event = '0;
    int_event[psl_pkg::EV_LINK_UP] = LINK_UP && !link_prev;
    int_event[psl_pkg::EV_LINK_DOWN] = !LINK_UP && link_prev;
    int_event[psl_pkg::EV_SPEED] = LINK_UP && link_prev && (SPEED_100 != speed_prev);
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    int_clear = '0;
    if (REG_WR && addr_hit(REG_ADDR, psl_pkg::ADDR_INT_STAT)) begin
      int_clear = REG_WDATA[psl_pkg::INT_W-1:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~int_clear) | int_event;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      int_mask <= psl_pkg::INT_MASK_RESET;
    end else if (REG_WR && addr_hit(REG_ADDR, psl_pkg::ADDR_INT_MASK)) begin
      int_mask <= REG_WDATA[psl_pkg::INT_W-1:0];
    end
  end

  assign irq_pending = |(int_stat & int_mask);

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~irq_pending;
    end
  end

  assign MGMT_INT_N_O = int_n;
  assign MGMT_INT_N_OE = drive;

  // ----------------------------------------------------------------
  // link/activity indicator
  // ----------------------------------------------------------------
  assign led_bus.link_up = LINK_UP;
  assign led_bus.activity = ACTIVITY;
  assign led_bus.led_enable = ctrl[psl_pkg::CTRL_LED_EN_BIT];

  psl_link_act #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_link_act (
    .clk(CORE_CLK),
    .rst(RST),
    .led(led_bus.engine)
  );

  assign LINK_ACT_INDICATOR_N_O = led_bus.led_n;
  assign LINK_ACT_INDICATOR_N_OE = drive;

  // ----------------------------------------------------------------
  // speed indicator
  // ----------------------------------------------------------------
  // low while the link runs at 100 Mb/s; dark without link
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      speed_led_n <= 1'b1;
    end else begin
      speed_led_n <= ~(LINK_UP && SPEED_100 && ctrl[psl_pkg::CTRL_LED_EN_BIT]);
    end
  end

  assign SPEED_INDICATOR_N_O = speed_led_n;
  assign SPEED_INDICATOR_N_OE = drive;

  // ----------------------------------------------------------------
  // latched configuration outputs
  // ----------------------------------------------------------------
  assign PHY_ADDR_STRAP = phy_addr_strap;
  assign TEST_MODE = ~test_strap;
  assign SPEED_SEL = ctrl[psl_pkg::CTRL_SPEED_BIT];

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // unmapped addresses read zero; data stands only in the cycle after the strobe
  always_comb begin
    rd_value = '0;
    if (addr_hit(REG_ADDR, psl_pkg::ADDR_CTRL)) begin
      rd_value = ctrl;
    end else if (addr_hit(REG_ADDR, psl_pkg::ADDR_STRAP)) begin
      rd_value[psl_pkg::STRAP_ADDR0_BIT] = phy_addr_strap;
      rd_value[psl_pkg::STRAP_TEST_BIT] = ~test_strap;
      rd_value[psl_pkg::STRAP_SPEED_BIT] = speed_strap_pin;
    end else if (addr_hit(REG_ADDR, psl_pkg::ADDR_INT_STAT)) begin
      rd_value = pad_int(int_stat);
    end else if (addr_hit(REG_ADDR, psl_pkg::ADDR_INT_MASK)) begin
      rd_value = pad_int(int_mask);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST || !REG_RD) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= rd_value;
    end
  end

endmodule

// ===== test/psl_board.sv
// board model: strap resistors and the host side of the three dual-use pins
// assumes each pin is driven by the transceiver only while its enable is high
`timescale 1ns/100ps
module psl_board (
  // transceiver pin drivers
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic la_o,
  input wire logic la_oe,
  input wire logic sp_o,
  input wire logic sp_oe,
  // strap resistors, 1 = pull-up, bit0 interrupt, bit1 link/act, bit2 speed
  input wire logic [2:0] pull,
  // resolved pin levels
  output logic int_i,
  output logic la_i,
  output logic sp_i
);
  // a released pin settles to its resistor, never to the last driven level
  assign int_i = int_oe ? int_o : pull[0];
  assign la_i = la_oe ? la_o : pull[1];
  assign sp_i = sp_oe ? sp_o : pull[2];
endmodule

// ===== test/psl_strap_pins_asserts.sv
// concurrent checks on the dual-use strap and indicator pins
// assumes it is bound to the pin top and sees its ports only
`timescale 1ns/100ps
module psl_strap_pins_asserts #(
  parameter int BLINK_CYCLES = psl_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register writes
  input wire logic [psl_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [psl_pkg::REG_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  // core status
  input wire logic LINK_UP,
  input wire logic ACTIVITY,
  // pins
  input wire logic MGMT_INT_N_I,
  input wire logic MGMT_INT_N_O,
  input wire logic MGMT_INT_N_OE,
  input wire logic LINK_ACT_INDICATOR_N_I,
  input wire logic LINK_ACT_INDICATOR_N_O,
  input wire logic LINK_ACT_INDICATOR_N_OE,
  input wire logic SPEED_INDICATOR_N_I,
  input wire logic SPEED_INDICATOR_N_OE,
  // latched straps
  input wire logic PHY_ADDR_STRAP,
  input wire logic TEST_MODE
);
  logic mask_any;
  logic led_en;
  int same;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // --------------------------------------------------------------
  // shadow state
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) mask_any <= 1'b0;
    else if (REG_WR && REG_ADDR == psl_pkg::ADDR_INT_MASK) mask_any <= |REG_WDATA[2:0];
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) led_en <= 1'b1;
    else if (REG_WR && REG_ADDR == psl_pkg::ADDR_CTRL) led_en <= REG_WDATA[0];
  end
  // cycles without a blink edge while traffic runs; lag allows two extra
  always_ff @(posedge CORE_CLK) begin
    if (RST || !(LINK_UP && ACTIVITY && led_en) || !$stable(LINK_ACT_INDICATOR_N_O)) same <= 0;
    else same <= same + 1;
  end
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  a_int_masked_high: assert property (!$past(mask_any) |-> MGMT_INT_N_O)
    else $error("interrupt pin low with all events masked");
  a_addr_strap: assert property ($fell(RST) |-> PHY_ADDR_STRAP == $past(MGMT_INT_N_I))
    else $error("address strap differs from pin level in reset");
  a_test_strap: assert property ($fell(RST) |-> TEST_MODE == !$past(LINK_ACT_INDICATOR_N_I))
    else $error("test mode differs from link pin level in reset");
  a_strap_hold: assert property (!$past(RST) |-> $stable({PHY_ADDR_STRAP, TEST_MODE}))
    else $error("strap value changed outside reset");
  a_link_off: assert property (!(LINK_UP && led_en) |=> LINK_ACT_INDICATOR_N_O)
    else $error("link indicator on without link");
  a_link_on: assert property (LINK_UP && !ACTIVITY && led_en |=> !LINK_ACT_INDICATOR_N_O)
    else $error("link indicator off with idle link");
  a_blink_period: assert property (same <= BLINK_CYCLES + 2)
    else $error("link indicator not blinking under traffic");
  a_pins_released: assert property (disable iff (1'b0) RST |=> !(MGMT_INT_N_OE
    || LINK_ACT_INDICATOR_N_OE || SPEED_INDICATOR_N_OE))
    else $error("pin driven during reset");
  a_pins_driven: assert property (!$past(RST) |-> MGMT_INT_N_OE && LINK_ACT_INDICATOR_N_OE
    && SPEED_INDICATOR_N_OE)
    else $error("pin not driven after reset");
  c_blink: cover property (same == BLINK_CYCLES - 1);
  c_int_low: cover property (!MGMT_INT_N_O);
  c_test_mode: cover property (TEST_MODE);
endmodule
bind psl_strap_pins psl_strap_pins_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) chk (.*);

// ===== test/psl_strap_pins_tb.sv
// self-checking bench for the dual-use strap and indicator pins
// assumes the board model resolves each pin from drivers and resistors
`timescale 1ns/100ps
`define CHK(nm, got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module psl_strap_pins_tb;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [psl_pkg::REG_AW-1:0] REG_ADDR = 4'h0;
  logic [psl_pkg::REG_DW-1:0] REG_WDATA = 16'h0000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [psl_pkg::REG_DW-1:0] REG_RDATA;
  logic LINK_UP = 1'b0;
  logic ACTIVITY = 1'b0;
  logic SPEED_100 = 1'b0;
  logic MGMT_INT_N_I, MGMT_INT_N_O, MGMT_INT_N_OE;
  logic LINK_ACT_INDICATOR_N_I, LINK_ACT_INDICATOR_N_O, LINK_ACT_INDICATOR_N_OE;
  logic SPEED_INDICATOR_N_I, SPEED_INDICATOR_N_O, SPEED_INDICATOR_N_OE;
  logic PHY_ADDR_STRAP, TEST_MODE, SPEED_SEL;
  logic [2:0] pull = 3'h0;
  logic [2:0] p;
  logic prev;
  int checked = 0;
  int n_fail = 0;
  int cyc = 0;
  int g, nt;
  psl_strap_pins #(.BLINK_CYCLES(4)) uut (.*);
  psl_board board (.int_o(MGMT_INT_N_O), .int_oe(MGMT_INT_N_OE), .la_o(LINK_ACT_INDICATOR_N_O),
    .la_oe(LINK_ACT_INDICATOR_N_OE), .sp_o(SPEED_INDICATOR_N_O), .sp_oe(SPEED_INDICATOR_N_OE),
    .pull(pull), .int_i(MGMT_INT_N_I), .la_i(LINK_ACT_INDICATOR_N_I), .sp_i(SPEED_INDICATOR_N_I));
  always #2 CORE_CLK = ~CORE_CLK;
  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    `CHK("read data", REG_RDATA, e)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a hang costs at most a few thousand cycles
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    // two boards: test pull-down with speed pull-up, then a normal board
    for (int c = 0; c < 2; c++) begin
      p = (c == 0) ? 3'h4 : 3'h3;
      @(posedge CORE_CLK);
      pull <= p;
      RST <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      RST <= 1'b0;
      tick(2);
      `CHK("addr strap", PHY_ADDR_STRAP, p[0])
      `CHK("test mode", TEST_MODE, ~p[1])
      `CHK("speed sel", SPEED_SEL, p[2])
      `CHK("enables", {MGMT_INT_N_OE, LINK_ACT_INDICATOR_N_OE, SPEED_INDICATOR_N_OE}, 3'h7)
      rd(psl_pkg::ADDR_STRAP, {13'h0000, p[2], ~p[1], p[0]});
      rd(psl_pkg::ADDR_CTRL, {2'h0, p[2], 12'h000, 1'b1});
    end
    wr(psl_pkg::ADDR_STRAP, 16'hffff);
    rd(psl_pkg::ADDR_STRAP, 16'h0001);
    tick(1);
    `CHK("rdata idle", REG_RDATA, 16'h0000)
    rd(4'h7, 16'h0000);
    wr(psl_pkg::ADDR_CTRL, 16'hffff);
    rd(psl_pkg::ADDR_CTRL, 16'h2001);
    `CHK("no link", LINK_ACT_INDICATOR_N_O, 1'b1)
    wr(psl_pkg::ADDR_INT_MASK, 16'h0007);
    @(posedge CORE_CLK);
    LINK_UP <= 1'b1;
    SPEED_100 <= 1'b1;
    tick(3);
    `CHK("link on", LINK_ACT_INDICATOR_N_O, 1'b0)
    `CHK("speed on", SPEED_INDICATOR_N_O, 1'b0)
    `CHK("int low", MGMT_INT_N_O, 1'b0)
    rd(psl_pkg::ADDR_INT_STAT, 16'h0001);
    wr(psl_pkg::ADDR_INT_STAT, 16'h0001);
    tick(2);
    `CHK("int high", MGMT_INT_N_O, 1'b1)
    @(posedge CORE_CLK);
    SPEED_100 <= 1'b0;
    tick(3);
    rd(psl_pkg::ADDR_INT_STAT, 16'h0004);
    wr(psl_pkg::ADDR_INT_STAT, 16'h0004);
    // traffic: every gap between blink edges is one blink period
    ACTIVITY <= 1'b1;
    g = 0;
    nt = 0;
    prev = LINK_ACT_INDICATOR_N_O;
    repeat (40) begin
      tick(1);
      g++;
      if (LINK_ACT_INDICATOR_N_O !== prev) begin
        if (nt > 0) `CHK("blink gap", g, 4)
        nt++;
        g = 0;
        prev = LINK_ACT_INDICATOR_N_O;
      end
    end
    `CHK("blink count", nt >= 8, 1'b1)
    // speed back to 100 so the enable bit is seen to darken the speed indicator too
    @(posedge CORE_CLK);
    ACTIVITY <= 1'b0;
    SPEED_100 <= 1'b1;
    tick(3);
    `CHK("idle link", LINK_ACT_INDICATOR_N_O, 1'b0)
    wr(psl_pkg::ADDR_CTRL, 16'h0000);
    tick(2);
    `CHK("leds off", {LINK_ACT_INDICATOR_N_O, SPEED_INDICATOR_N_O}, 2'h3)
    @(posedge CORE_CLK);
    LINK_UP <= 1'b0;
    wr(psl_pkg::ADDR_INT_MASK, 16'h0000);
    tick(2);
    `CHK("int masked", MGMT_INT_N_O, 1'b1)
    rd(psl_pkg::ADDR_INT_STAT, 16'h0006);
    results();
  end
endmodule
